// ---- hdl/iom_core.sv ----
/*
 * index operand modifier: word store, index banks, operand offset,
 * branch pointer check and interrupt sources.
 * assumes the scan engine drives single-cycle requests synchronous to clk_sys_i
 */
`timescale 1ns/10ps
`default_nettype none
module iom_core #(
    parameter int CYC_PER_MS_P = iom_pkg::CYC_PER_MS
) (
    input  wire logic                  clk_sys_i,
    input  wire logic                  rst_i,
    input  wire logic                  large_variant_i,
    input  wire logic                  w_wr_i,
    input  wire logic                  w_wide_i,
    input  wire logic [8:0]            w_addr_i,
    input  wire logic [31:0]           w_wdata_i,
    output logic      [31:0]           w_rdata_o,
    input  wire logic                  idx_wr_i,
    input  wire logic                  idx_wide_i,
    input  wire logic                  idx_high_i,
    input  wire logic [3:0]            idx_sel_i,
    input  wire logic [31:0]           idx_wdata_i,
    output logic      [31:0]           idx_rdata_o,
    input  wire logic                  mod_req_i,
    input  wire logic [2:0]            mod_kind_i,
    input  wire logic                  mod_use_high_i,
    input  wire logic [3:0]            mod_sel_i,
    input  wire logic [31:0]           mod_base_i,
    input  wire logic [31:0]           mod_limit_i,
    output logic      [31:0]           mod_result_o,
    output logic                       mod_valid_o,
    output logic                       mod_error_o,
    input  wire logic [7:0]            branch_num_i,
    output logic                       branch_ok_o,
    input  wire logic [5:0]            edge_in_i,
    input  wire logic [5:0]            edge_rise_en_i,
    input  wire logic [5:0]            cnt_match_i,
    input  wire logic [2:0]            time_en_i,
    input  wire logic [20:0]           time_ms_i,
    input  wire logic [1:0]            irq_cmd_i,
    input  wire logic [3:0]            irq_ack_idx_i,
    output logic      [14:0]           irq_pending_o,
    output logic                       irq_req_o,
    output logic                       irq_busy_o
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [5:0]  edge_prev;
        logic [14:0] pend;
        logic        glob_en;
        logic        busy;
        logic [31:0] result;
        logic        valid;
        logic        error;
        logic [2:0][6:0]  ms_cnt;
        logic [2:0][23:0] sub_cnt;
    } iom_state_t;

    iom_state_t state_reg;
    iom_state_t state_next;

    // storage arrays have no reset: contents are undefined after stop
    logic [15:0] word_mem [iom_pkg::W_COUNT];    // signed words
    logic [15:0] idx_lo [iom_pkg::IDX_COUNT];
    logic [15:0] idx_hi [iom_pkg::IDX_COUNT];
    logic [8:0]  w_next_addr;
    logic [31:0] idx_val;
    logic [31:0] oct_val;
    logic [31:0] sum;
    logic [31:0] oct_sum;
    logic [3:0]  oct_dig;
    logic        oct_carry;

    // ------------------------------------------------------------
    // word store
    // ------------------------------------------------------------
    assign w_next_addr = w_addr_i + 9'h001;

    always_ff @(posedge clk_sys_i) begin
        if (w_wr_i) begin
            word_mem[w_addr_i] <= w_wdata_i[15:0];
            if (w_wide_i) begin
                word_mem[w_next_addr] <= w_wdata_i[31:16];
            end
        end
        if (idx_wr_i) begin
            if (idx_wide_i) begin
                idx_lo[idx_sel_i] <= idx_wdata_i[15:0];
                idx_hi[idx_sel_i] <= idx_wdata_i[31:16];
            end else if (idx_high_i) begin
                idx_hi[idx_sel_i] <= idx_wdata_i[15:0];
            end else begin
                idx_lo[idx_sel_i] <= idx_wdata_i[15:0];
            end
        end
    end

    // combinational read; a narrow word read sign-extends, a narrow index read zero-extends
    assign w_rdata_o = w_wide_i ? {word_mem[w_next_addr], word_mem[w_addr_i]}
                                : {{16{word_mem[w_addr_i][15]}}, word_mem[w_addr_i]};
    assign idx_rdata_o = idx_wide_i ? {idx_hi[idx_sel_i], idx_lo[idx_sel_i]}
                                    : {16'h0000, idx_high_i ? idx_hi[idx_sel_i] : idx_lo[idx_sel_i]};

    // ------------------------------------------------------------
    // operand modification
    // ------------------------------------------------------------
    // naming only the high bank yields no offset
    assign idx_val = mod_use_high_i ? 32'h0000_0000 : {idx_hi[mod_sel_i], idx_lo[mod_sel_i]};

    // index converted to octal digits so X0 + 10 reads as X12
    always_comb begin
        oct_val = 32'h0000_0000;
        for (int d = 0; d < 8; d++) begin
            oct_val[d*4 +: 4] = 4'((idx_val >> (3 * d)) & 32'h7);
        end
    end

    // octal operands carry one octal digit per nibble; a plain binary add would
    // leave digits 8..F behind, so each digit carries into the next one
    always_comb begin
        oct_sum   = 32'h0000_0000;
        oct_carry = 1'b0;
        oct_dig   = 4'h0;
        for (int d = 0; d < 8; d++) begin
            oct_dig   = 4'(mod_base_i[d*4 +: 3]) + 4'(oct_val[d*4 +: 3]) + 4'(oct_carry);
            oct_carry = oct_dig[3];
            oct_sum[d*4 +: 4] = {1'b0, oct_dig[2:0]};
        end
    end

    always_comb begin
        unique case (iom_pkg::iom_kind_t'(mod_kind_i))
            iom_pkg::IOM_K_OCT:  sum = oct_sum;
            iom_pkg::IOM_K_HEX:  sum = mod_base_i + idx_val;
            iom_pkg::IOM_K_KDEC: sum = mod_base_i + idx_val;
            default:             sum = mod_base_i + idx_val;
        endcase
    end

    // branch pointer count depends on variant
    assign branch_ok_o = large_variant_i ? 1'b1 : (branch_num_i < 8'(iom_pkg::BRANCH_SMALL));

    // ------------------------------------------------------------
    // interrupts and next state
    // ------------------------------------------------------------
    logic [14:0] ev;
    logic [3:0]  ack_idx;

    always_comb begin
        state_next = state_reg;
        ev = 15'h0000;
        ack_idx = irq_ack_idx_i;
        state_next.valid = mod_req_i;
        if (mod_req_i) begin
            state_next.result = sum;
            // limit check for decimal/octal element numbers, constants are unbounded
            state_next.error = (mod_kind_i == 3'(iom_pkg::IOM_K_DEC) ||
                                mod_kind_i == 3'(iom_pkg::IOM_K_OCT)) &&
                               ($signed(sum) < 0 || sum >= mod_limit_i);
        end
        state_next.edge_prev = edge_in_i;
        // edges caught every clock, not every scan
        for (int i = 0; i < iom_pkg::EDGE_INPUTS; i++) begin
            ev[iom_pkg::IRQ_EDGE_BASE + i] = edge_rise_en_i[i] ? (edge_in_i[i] & ~state_reg.edge_prev[i])
                                                                : (~edge_in_i[i] & state_reg.edge_prev[i]);
        end
        // small variant has four edge inputs only
        if (!large_variant_i) begin
            ev[5:4] = 2'b00;
        end
        for (int t = 0; t < iom_pkg::TIME_CHANNELS; t++) begin
            if (!time_en_i[t]) begin
                state_next.ms_cnt[t]  = 7'h00;
                state_next.sub_cnt[t] = 24'h000000;
            end else if (state_reg.sub_cnt[t] >= 24'(CYC_PER_MS_P - 1)) begin
                state_next.sub_cnt[t] = 24'h000000;
                // period clamped into 10..99 ms
                if (32'(state_reg.ms_cnt[t]) + 1 >=
                    ((32'(time_ms_i[t*7 +: 7]) < iom_pkg::PERIOD_MIN_MS) ? iom_pkg::PERIOD_MIN_MS :
                     (32'(time_ms_i[t*7 +: 7]) > iom_pkg::PERIOD_MAX_MS) ? iom_pkg::PERIOD_MAX_MS :
                     32'(time_ms_i[t*7 +: 7]))) begin
                    state_next.ms_cnt[t] = 7'h00;
                    ev[iom_pkg::IRQ_TIME_BASE + t] = 1'b1;
                end else begin
                    state_next.ms_cnt[t] = state_reg.ms_cnt[t] + 7'h01;
                end
            end else begin
                state_next.sub_cnt[t] = state_reg.sub_cnt[t] + 24'h000001;
            end
        end
        ev[iom_pkg::IRQ_CNT_BASE +: iom_pkg::CNT_IRQS] = cnt_match_i;
        unique case (iom_pkg::iom_cmd_t'(irq_cmd_i))
            iom_pkg::IOM_C_EN:   state_next.glob_en = 1'b1;
            iom_pkg::IOM_C_MASK: state_next.glob_en = 1'b0;
            iom_pkg::IOM_C_RET: begin
                state_next.busy = 1'b0;
                if (ack_idx < 4'(iom_pkg::IRQ_COUNT)) begin
                    state_next.pend[ack_idx] = 1'b0;
                end
            end
            iom_pkg::IOM_C_NONE: ;
        endcase
        // a new event wins over a same-cycle return
        state_next.pend = state_next.pend | ev;
        if (state_reg.glob_en && !state_reg.busy && (state_reg.pend != 15'h0000)) begin
            state_next.busy = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign mod_result_o  = state_reg.result;
    assign mod_valid_o   = state_reg.valid;
    assign mod_error_o   = state_reg.error;
    assign irq_pending_o = state_reg.pend;
    assign irq_busy_o    = state_reg.busy;
    assign irq_req_o     = state_reg.glob_en && !state_reg.busy && (state_reg.pend != 15'h0000);

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_edge_sets_pend: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (edge_rise_en_i[0] && edge_in_i[0] && !state_reg.edge_prev[0]) |=> state_reg.pend[0])
        else $error("edge event not latched");
    chk_cnt_sets_pend: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (cnt_match_i != 6'h00) |=> ((state_reg.pend[14:9] & $past(cnt_match_i)) == $past(cnt_match_i)))
        else $error("counter match not latched");
    chk_enable_cmd: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (irq_cmd_i == 2'h2) |=> state_reg.glob_en)
        else $error("enable command ignored");
    chk_mask_blocks: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (irq_cmd_i == 2'h3) |=> !irq_req_o)
        else $error("request while masked");
    chk_mod_valid: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        mod_req_i |=> mod_valid_o)
        else $error("modified operand not flagged valid");
    chk_valid_pulse: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        !mod_req_i |=> !mod_valid_o)
        else $error("valid without request");
    chk_dec_offset: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (mod_req_i && mod_kind_i == 3'h0 && !mod_use_high_i) |=>
            (mod_result_o == $past(mod_base_i) + $past(idx_val)))
        else $error("decimal operand offset wrong");
    chk_error_range: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (mod_req_i && mod_kind_i == 3'h0 && sum >= mod_limit_i && !sum[31]) |=> mod_error_o)
        else $error("range error missed");
    chk_high_no_mod: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (mod_req_i && mod_use_high_i) |=> (mod_result_o == $past(mod_base_i)))
        else $error("high bank modified operand");
    chk_branch_small: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (!large_variant_i && branch_num_i[7]) |-> !branch_ok_o)
        else $error("small variant branch accepted");
    chk_timer_period: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        ev[iom_pkg::IRQ_TIME_BASE] |-> (state_reg.ms_cnt[0] >= 7'h09 && state_reg.ms_cnt[0] <= 7'h62))
        else $error("timer period outside clamp");
endmodule // iom_core
`default_nettype wire

// ---- hdl/iom_pkg.sv ----
/*
 * constants and types for the index operand modifier
 * assumes a single system clock domain at 100 MHz
 */
`default_nettype none
package iom_pkg;
    localparam int W_COUNT        = 512;
    localparam int W_AW           = 9;
    localparam int IDX_COUNT      = 16;
    localparam logic [15:0] WORD_RST    = 16'h0000;
    localparam int BRANCH_LARGE   = 256;
    localparam int BRANCH_SMALL   = 128;
    localparam int EDGE_INPUTS    = 6;
    localparam int CNT_IRQS       = 6;
    localparam int IRQ_COUNT      = 15;
    localparam int IRQ_EDGE_BASE  = 0;
    localparam int IRQ_TIME_BASE  = 6;
    localparam int IRQ_CNT_BASE   = 9;
    localparam int TIME_CHANNELS  = 3;
    localparam int PERIOD_MIN_MS  = 10;
    localparam int PERIOD_MAX_MS  = 99;
    localparam int CLK_PERIOD_NS  = 10;
    localparam int MS_NS          = 1000000;
    localparam int CYC_PER_MS     = MS_NS / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        IOM_K_DEC = 3'h0,
        IOM_K_OCT = 3'h1,
        IOM_K_HEX = 3'h2,
        IOM_K_KDEC = 3'h3
    } iom_kind_t;

    typedef enum logic [1:0] {
        IOM_C_NONE = 2'h0,
        IOM_C_RET  = 2'h1,
        IOM_C_EN   = 2'h2,
        IOM_C_MASK = 2'h3
    } iom_cmd_t;
endpackage
`default_nettype wire

// ---- tb/iom_core_test.sv ----
/*
 * self-checking bench for iom_core: word store, index banks, operand offset,
 * branch pointer range and interrupt sources.
 * assumes the design runs with one millisecond shortened to 10 clock cycles.
 */
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_count++; \
    $display("BAD t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module iom_core_test;
    // ------
    // signals
    // ------
    logic        clk = 1'b0, rst = 1'b1, lv, w_wr, w_wide, i_wr, i_wide, i_high, m_req, m_hi;
    logic [8:0]  w_addr;
    logic [31:0] w_wd, i_wd, m_base, m_lim;
    logic [3:0]  i_sel, ack;
    logic [2:0]  m_kind, t_en;
    logic [7:0]  br;
    logic [5:0]  ein, rise, cm;
    logic [20:0] t_ms;
    logic [1:0]  cmd;
    wire logic [31:0] w_rd, i_rd, m_res;
    wire logic        m_val, m_err, br_ok, irq, busy;
    wire logic [14:0] pend;
    int err_count = 0, total_checks = 0, cyc_count = 0;

    iom_core #(.CYC_PER_MS_P(10)) dut_u (
        .clk_sys_i(clk), .rst_i(rst), .large_variant_i(lv), .w_wr_i(w_wr), .w_wide_i(w_wide),
        .w_addr_i(w_addr), .w_wdata_i(w_wd), .w_rdata_o(w_rd), .idx_wr_i(i_wr), .idx_wide_i(i_wide),
        .idx_high_i(i_high), .idx_sel_i(i_sel), .idx_wdata_i(i_wd), .idx_rdata_o(i_rd),
        .mod_req_i(m_req), .mod_kind_i(m_kind), .mod_use_high_i(m_hi), .mod_sel_i(4'h1),
        .mod_base_i(m_base), .mod_limit_i(m_lim), .mod_result_o(m_res), .mod_valid_o(m_val),
        .mod_error_o(m_err), .branch_num_i(br), .branch_ok_o(br_ok), .edge_in_i(ein),
        .edge_rise_en_i(rise), .cnt_match_i(cm), .time_en_i(t_en), .time_ms_i(t_ms),
        .irq_cmd_i(cmd), .irq_ack_idx_i(ack), .irq_pending_o(pend), .irq_req_o(irq), .irq_busy_o(busy));

    always #5 clk = ~clk;
    // ceiling well above the few hundred cycles that the scenarios need
    always @(posedge clk) begin
        cyc_count++;
        if (cyc_count == 5000) begin
            err_count++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // ------
    // bus helpers
    // ------
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wwr(input logic wd, input logic [8:0] a, input logic [31:0] d);
        @(posedge clk);
        {w_wr, w_wide, w_addr, w_wd} <= {1'b1, wd, a, d};
        @(posedge clk);
        w_wr <= 1'b0;
        #1;
    endtask
    task automatic wsel(input logic wd, input logic [8:0] a);
        @(posedge clk);
        {w_wide, w_addr} <= {wd, a};
        #1;
    endtask
    task automatic iwr(input logic wd, input logic hi, input logic [3:0] s, input logic [31:0] d);
        @(posedge clk);
        {i_wr, i_wide, i_high, i_sel, i_wd} <= {1'b1, wd, hi, s, d};
        @(posedge clk);
        i_wr <= 1'b0;
        #1;
    endtask
    task automatic mchk(input logic [2:0] k, input logic hi, input logic [31:0] b, l, r, input logic e);
        @(posedge clk);
        {m_req, m_kind, m_hi, m_base, m_lim} <= {1'b1, k, hi, b, l};
        @(posedge clk);
        m_req <= 1'b0;
        #1;
        `CHK(m_val, 1'b1)
        `CHK(m_err, e)
        if (!e) `CHK(m_res, r)
    endtask
    task automatic bchk(input logic l, input logic [7:0] n, input logic e);
        @(posedge clk);
        {lv, br} <= {l, n};
        #1;
        `CHK(br_ok, e)
    endtask
    task automatic cmdx(input logic [1:0] c, input logic [3:0] a);
        @(posedge clk);
        {cmd, ack} <= {c, a};
        @(posedge clk);
        cmd <= 2'h0;
        #1;
    endtask
    task automatic edge_to(input logic [5:0] v);
        @(posedge clk);
        ein <= v;
        #1;
    endtask
    task automatic wait_tick();
        int n;
        n = 0;
        while (pend[6] !== 1'b1 && n < 300) begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask
    // ------
    // scenarios
    // ------
    task automatic t_store();
        wwr(1'b0, 9'h005, 32'h00008000);
        wsel(1'b0, 9'h005);
        `CHK(w_rd, 32'hFFFF8000)
        wwr(1'b1, 9'h1FF, 32'h12345678);
        wsel(1'b0, 9'h1FF);
        `CHK(w_rd, 32'h00005678)
        wsel(1'b0, 9'h000);
        `CHK(w_rd, 32'h00001234)
        wwr(1'b1, 9'h007, 32'h87654321);
        wsel(1'b1, 9'h007);
        `CHK(w_rd, 32'h87654321)
        iwr(1'b1, 1'b0, 4'h3, 32'hABCD0123);
        iwr(1'b0, 1'b1, 4'hF, 32'h00000005);
        iwr(1'b0, 1'b0, 4'hF, 32'h00000009);
        @(posedge clk);
        {i_wide, i_sel} <= {1'b1, 4'hF};
        tick(1);
        `CHK(i_rd, 32'h00050009)
        @(posedge clk);
        i_sel <= 4'h3;
        tick(1);
        `CHK(i_rd, 32'hABCD0123)
    endtask
    task automatic t_irq();
        @(posedge clk);
        rise <= 6'h01;
        cmdx(2'h2, 4'h0);
        edge_to(6'h01);
        edge_to(6'h00);
        tick(3);
        `CHK({pend[0], busy}, 2'b11)
        cmdx(2'h1, 4'h0);
        `CHK({busy, pend[0]}, 2'b00)
        cmdx(2'h3, 4'h0);
        edge_to(6'h02);
        tick(3);
        `CHK(pend[1], 1'b0)
        edge_to(6'h00);
        @(posedge clk);
        cm <= 6'h04; // counter source kept apart from the edge inputs
        @(posedge clk);
        cm <= 6'h00;
        tick(3);
        `CHK({pend[11], pend[1], irq, busy}, 4'b1100)
        cmdx(2'h2, 4'h0);
        tick(2);
        `CHK(busy, 1'b1)
        cmdx(2'h1, 4'h1);
        `CHK({pend[11], pend[1]}, 2'b10)
        cmdx(2'h3, 4'h0);
        cmdx(2'h1, 4'hB);
        `CHK(pend[11], 1'b0)
    endtask
    task automatic t_timer();
        longint t0;
        @(posedge clk);
        {t_ms, t_en} <= {21'd10, 3'b001};
        wait_tick();
        t0 = $time;
        `CHK(pend[6], 1'b1)
        cmdx(2'h1, 4'h6);
        `CHK(pend[6], 1'b0)
        wait_tick();
        `CHK(32'(($time - t0) / 10), 32'd100)
    endtask

    initial begin
        {lv, w_wr, w_wide, i_wr, i_wide, i_high, m_req, m_hi, w_addr, w_wd, i_wd, m_base, m_lim} = '0;
        {i_sel, ack, m_kind, t_en, br, ein, rise, cm, t_ms, cmd} = '0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        t_store();
        iwr(1'b1, 1'b0, 4'h1, 32'h0000000A);
        mchk(3'h0, 1'b0, 32'd20, 32'd100, 32'd30, 1'b0);
        mchk(3'h1, 1'b0, 32'd0, 32'd100, 32'h12, 1'b0);
        mchk(3'h1, 1'b0, 32'h07, 32'd100, 32'h21, 1'b0);
        mchk(3'h2, 1'b0, 32'h30, 32'd0, 32'h3A, 1'b0);
        mchk(3'h3, 1'b0, 32'd30, 32'd0, 32'd40, 1'b0);
        mchk(3'h0, 1'b1, 32'd20, 32'd100, 32'd20, 1'b0);
        mchk(3'h0, 1'b0, 32'd89, 32'd100, 32'd99, 1'b0);
        mchk(3'h0, 1'b0, 32'd90, 32'd100, 32'd0, 1'b1);
        bchk(1'b1, 8'hFF, 1'b1);
        bchk(1'b0, 8'h7F, 1'b1);
        bchk(1'b0, 8'h80, 1'b0);
        bchk(1'b1, 8'h80, 1'b1);
        t_irq();
        t_timer();
        stop_test();
    end
endmodule // iom_core_test
`default_nettype wire
